/* File: core/hpbp_device.sv */
`timescale 1ns/1ps
module hpbp_device (
  input  wire logic       i_core_clk,
  input  wire logic       i_sys_rst,
  hpbp_if.device          bus_if,
  input  wire logic       i_dir_style,
  output logic            o_rd_stb,
  output logic            o_wr_stb,
  output logic            o_hdlc_sel,
  output logic [7:0]      o_addr,
  output logic [7:0]      o_wr_data,
  input  wire logic [7:0] i_rd_data,
  output logic            o_mode_known,
  output logic            o_mux_mode
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    hpbp_pkg::hpbp_pins_t      s1;
    hpbp_pkg::hpbp_pins_t      s2;
    hpbp_pkg::hpbp_dev_state_t state;
    logic                      mode_known;
    logic                      mux_mode;
    logic                      ale_seen;
    logic [7:0]                alatch;
    logic                      hdlc_sel;
    logic [7:0]                addr;
    logic [7:0]                wdata;
    logic [7:0]                rdata;
    logic                      drive;
    logic                      rd_stb;
    logic                      wr_stb;
  } hpbp_dev_st_t;

  localparam hpbp_dev_st_t DEV_RESET = '{
    s1:      hpbp_pkg::PINS_IDLE,
    s2:      hpbp_pkg::PINS_IDLE,
    state:   hpbp_pkg::DEV_IDLE,
    default: '0
  };

  hpbp_dev_st_t         st;
  hpbp_dev_st_t         next_st;
  hpbp_pkg::hpbp_pins_t pins_now;
  logic                 sel_general;
  logic                 sel_hdlc;
  logic                 access;
  logic                 is_read;
  logic                 latch_open;
  logic                 mux_now;

  // ----------------------------------------------------------------
  // decode helpers, applied to the synchronised pin image
  // ----------------------------------------------------------------
  // strobe active for the chosen bus style
  function automatic logic f_strobe(input hpbp_pkg::hpbp_pins_t p,
                                    input logic                 dir);
    if (dir) begin
      return !p.read_or_data_strobe;
    end
    return !p.read_or_data_strobe || !p.write_or_dir;
  endfunction

  // direction of an access for the chosen bus style
  function automatic logic f_is_read(input hpbp_pkg::hpbp_pins_t p,
                                     input logic                 dir);
    if (dir) begin
      return p.write_or_dir;
    end
    return !p.read_or_data_strobe;
  endfunction

  // ----------------------------------------------------------------
  // pin capture
  // ----------------------------------------------------------------
  // every pin is asynchronous to i_core_clk; the whole bundle goes
  // through two flops, so a multi-bit skew can only cost a cycle
  always_comb begin
    pins_now.general_chip_select_n   = bus_if.general_chip_select_n;
    pins_now.hdlc_regs_chip_select_n = bus_if.hdlc_regs_chip_select_n;
    pins_now.write_or_dir            = bus_if.write_or_dir;
    pins_now.read_or_data_strobe     = bus_if.read_or_data_strobe;
    pins_now.addr_latch_en           = bus_if.addr_latch_en;
    pins_now.shared_bus              = bus_if.shared_bus;
    pins_now.addr                    = bus_if.addr;
  end

  // ----------------------------------------------------------------
  // select and access decode
  // ----------------------------------------------------------------
  // both selects low is treated as a general access; the two register
  // sets never answer together
  assign sel_general = !st.s2.general_chip_select_n;
  assign sel_hdlc    = !st.s2.hdlc_regs_chip_select_n && !sel_general;
  assign access      = (sel_general || sel_hdlc) && f_strobe(st.s2, i_dir_style);
  assign is_read     = f_is_read(st.s2, i_dir_style);

  // latch is transparent until the mode is known, then only in mux mode
  assign latch_open  = st.s2.addr_latch_en && (st.mux_mode || !st.mode_known);

  // the mode in force for the access that starts now
  assign mux_now     = st.mode_known ? st.mux_mode
                                     : (st.ale_seen || st.s2.addr_latch_en);

  // ----------------------------------------------------------------
  // access sequencer
  // ----------------------------------------------------------------
  always_comb begin
    next_st        = st;
    next_st.s1     = pins_now;
    next_st.s2     = st.s1;
    next_st.rd_stb = 1'b0;
    next_st.wr_stb = 1'b0;

    // address latch follows the lines while enabled and freezes on the fall
    if (latch_open) begin
      next_st.alatch = st.s2.shared_bus;
    end

    // remember a latch enable pulse seen before the mode is settled
    if (!st.mode_known && st.s2.addr_latch_en) begin
      next_st.ale_seen = 1'b1;
    end

    unique case (st.state)
      hpbp_pkg::DEV_IDLE: begin
        next_st.drive = 1'b0;
        if (access) begin
          // first access after reset fixes the mode until the next reset
          if (!st.mode_known) begin
            next_st.mode_known = 1'b1;
            next_st.mux_mode   = mux_now;
          end
          next_st.hdlc_sel = sel_hdlc;
          if (mux_now) begin
            next_st.addr = st.alatch;
          end else begin
            next_st.addr = st.s2.addr;
          end
          if (is_read) begin
            next_st.rd_stb = 1'b1;
            next_st.state  = hpbp_pkg::DEV_READ;
          end else begin
            next_st.state  = hpbp_pkg::DEV_WRITE;
            next_st.wdata  = st.s2.shared_bus;
          end
        end
      end

      hpbp_pkg::DEV_READ: begin
        // user answers in the strobe cycle; the answer is held in flops
        if (st.rd_stb) begin
          next_st.rdata = i_rd_data;
          next_st.drive = 1'b1;
        end
        // strobe release ends the read and frees the lines at once
        if (!access) begin
          next_st.drive = 1'b0;
          next_st.state = hpbp_pkg::DEV_IDLE;
        end
      end

      hpbp_pkg::DEV_WRITE: begin
        // data is tracked until the end, so late-settling host data is kept
        if (access) begin
          next_st.wdata = st.s2.shared_bus;
        end else begin
          next_st.wr_stb = 1'b1;
          next_st.state  = hpbp_pkg::DEV_IDLE;
        end
      end
    endcase
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      st <= DEV_RESET;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // lines released except while returning read data
  assign bus_if.dev_bus_out  = st.rdata;
  assign bus_if.dev_bus_oe_n = !st.drive;

  // user side
  assign o_rd_stb     = st.rd_stb;
  assign o_wr_stb     = st.wr_stb;
  assign o_hdlc_sel   = st.hdlc_sel;
  assign o_addr       = st.addr;
  assign o_wr_data    = st.wdata;
  assign o_mode_known = st.mode_known;
  assign o_mux_mode   = st.mux_mode;

endmodule

/* File: core/hpbp_host.sv */
`timescale 1ns/1ps
module hpbp_host (
  input  wire logic       i_core_clk,
  input  wire logic       i_sys_rst,
  hpbp_if.host            bus_if,
  input  wire logic       i_mux_mode,
  input  wire logic       i_dir_style,
  input  wire logic       i_req,
  input  wire logic       i_write,
  input  wire logic       i_hdlc,
  input  wire logic [7:0] i_addr,
  input  wire logic [7:0] i_wdata,
  output logic            o_busy,
  output logic            o_done,
  output logic [7:0]      o_rd_data
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    hpbp_pkg::hpbp_host_state_t state;
    logic [3:0]                 cnt;
    logic                       write;
    logic                       hdlc;
    logic                       dir_style;
    logic [7:0]                 wdata;
    logic                       cs_g_n;
    logic                       cs_h_n;
    logic                       write_or_dir;
    logic                       read_or_ds;
    logic                       ale;
    logic [7:0]                 addr;
    logic [7:0]                 bus_out;
    logic                       bus_drive;
    logic [7:0]                 bus_s1;
    logic [7:0]                 bus_s2;
    logic [7:0]                 rd_data;
    logic                       done;
  } hpbp_host_st_t;

  localparam hpbp_host_st_t HOST_RESET = '{
    state:        hpbp_pkg::HOST_IDLE,
    cs_g_n:       1'b1,
    cs_h_n:       1'b1,
    write_or_dir: 1'b1,
    read_or_ds:   1'b1,
    bus_s1:       8'hff,
    bus_s2:       8'hff,
    default:      '0
  };

  hpbp_host_st_t st;
  hpbp_host_st_t next_st;

  // ----------------------------------------------------------------
  // start of the strobe phase, reached from idle or after the latch
  // ----------------------------------------------------------------
  function automatic hpbp_host_st_t f_enter_strobe(input hpbp_host_st_t s);
    hpbp_host_st_t r;
    r         = s;
    r.state   = hpbp_pkg::HOST_STROBE;
    r.cnt     = hpbp_pkg::STROBE_CYCLES;
    r.ale     = 1'b0;
    r.cs_g_n  = s.hdlc;
    r.cs_h_n  = !s.hdlc;
    if (s.dir_style) begin
      r.write_or_dir = !s.write;
      r.read_or_ds   = 1'b0;
    end else begin
      r.write_or_dir = !s.write;
      r.read_or_ds   = s.write;
    end
    // address phase over; only a write keeps the lines driven, now with data
    r.bus_drive = s.write;
    r.bus_out   = s.wdata;
    return r;
  endfunction

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  always_comb begin
    next_st        = st;
    next_st.done   = 1'b0;
    next_st.bus_s1 = bus_if.shared_bus;
    next_st.bus_s2 = st.bus_s1;
    if (st.state != hpbp_pkg::HOST_IDLE && st.cnt != hpbp_pkg::CNT_ZERO) begin
      next_st.cnt = st.cnt - hpbp_pkg::CNT_ONE;
    end else begin
      unique case (st.state)
        hpbp_pkg::HOST_IDLE: begin
          if (i_req) begin
            next_st.write     = i_write;
            next_st.hdlc      = i_hdlc;
            next_st.wdata     = i_wdata;
            next_st.dir_style = i_dir_style;
            if (i_mux_mode) begin
              // latch enable pulses ahead of every access, so also the first
              next_st.state     = hpbp_pkg::HOST_ALE;
              next_st.cnt       = hpbp_pkg::ALE_CYCLES;
              next_st.ale       = 1'b1;
              next_st.bus_out   = i_addr;
              next_st.bus_drive = 1'b1;
            end else begin
              next_st.addr = i_addr;
              next_st      = f_enter_strobe(next_st);
              next_st.addr = i_addr;
            end
          end
        end
        hpbp_pkg::HOST_ALE: begin
          // address still held after the falling edge
          next_st.ale   = 1'b0;
          next_st.state = hpbp_pkg::HOST_LATCH;
          next_st.cnt   = hpbp_pkg::ADDR_HOLD;
        end
        hpbp_pkg::HOST_LATCH: begin
          next_st = f_enter_strobe(st);
          next_st.bus_s1 = bus_if.shared_bus;
          next_st.bus_s2 = st.bus_s1;
          next_st.done   = 1'b0;
        end
        hpbp_pkg::HOST_STROBE: begin
          if (!st.write) begin
            next_st.rd_data = st.bus_s2;
          end
          // strobe rises first; write data stays through the release phase
          next_st.read_or_ds   = 1'b1;
          next_st.write_or_dir = 1'b1;
          next_st.cs_g_n       = 1'b1;
          next_st.cs_h_n       = 1'b1;
          next_st.state        = hpbp_pkg::HOST_RELEASE;
          next_st.cnt          = hpbp_pkg::RELEASE_CYCLES;
        end
        hpbp_pkg::HOST_RELEASE: begin
          next_st.bus_drive = 1'b0;
          next_st.state     = hpbp_pkg::HOST_GAP;
          next_st.cnt       = hpbp_pkg::GAP_CYCLES;
        end
        hpbp_pkg::HOST_GAP: begin
          next_st.done  = 1'b1;
          next_st.state = hpbp_pkg::HOST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      st <= HOST_RESET;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign bus_if.general_chip_select_n   = st.cs_g_n;
  assign bus_if.hdlc_regs_chip_select_n = st.cs_h_n;
  assign bus_if.write_or_dir            = st.write_or_dir;
  assign bus_if.read_or_data_strobe     = st.read_or_ds;
  assign bus_if.addr_latch_en           = st.ale;
  assign bus_if.addr                    = st.addr;
  assign bus_if.host_bus_out            = st.bus_out;
  assign bus_if.host_bus_oe_n           = !st.bus_drive;
  assign o_busy    = (st.state != hpbp_pkg::HOST_IDLE);
  assign o_done    = st.done;
  assign o_rd_data = st.rd_data;

endmodule

/* File: core/hpbp_if.sv */
`timescale 1ns/1ps
interface hpbp_if;

  // ----------------------------------------------------------------
  // pins driven by the host
  // ----------------------------------------------------------------
  logic       general_chip_select_n;
  logic       hdlc_regs_chip_select_n;
  logic       write_or_dir;
  logic       read_or_data_strobe;
  logic       addr_latch_en;
  logic [7:0] addr;

  // ----------------------------------------------------------------
  // two-way shared lines, one driver half per end
  // ----------------------------------------------------------------
  logic [7:0] host_bus_out;
  logic       host_bus_oe_n;
  logic [7:0] dev_bus_out;
  logic       dev_bus_oe_n;
  logic [7:0] shared_bus;

  // resolved level; host wins a clash, undriven lines float high
  assign shared_bus = !host_bus_oe_n ? host_bus_out :
                      !dev_bus_oe_n  ? dev_bus_out  : hpbp_pkg::BUS_IDLE;

  modport device (
    input  general_chip_select_n,
    input  hdlc_regs_chip_select_n,
    input  write_or_dir,
    input  read_or_data_strobe,
    input  addr_latch_en,
    input  addr,
    input  shared_bus,
    output dev_bus_out,
    output dev_bus_oe_n
  );

  modport host (
    output general_chip_select_n,
    output hdlc_regs_chip_select_n,
    output write_or_dir,
    output read_or_data_strobe,
    output addr_latch_en,
    output addr,
    output host_bus_out,
    output host_bus_oe_n,
    input  shared_bus
  );

endinterface

/* File: core/hpbp_pkg.sv */
package hpbp_pkg;

  // ----------------------------------------------------------------
  // bus levels and widths
  // ----------------------------------------------------------------
  localparam int unsigned BUS_W    = 8;
  localparam int unsigned CNT_W    = 4;
  localparam logic [7:0]  BUS_IDLE = 8'hff;   // pulled-up level of an undriven bus

  // ----------------------------------------------------------------
  // host timing, in i_core_clk cycles (a loaded count n lasts n+1 cycles)
  // ----------------------------------------------------------------
  // the device syncs every pin through two flops, so each phase must
  // outlast that latency plus the device's one-cycle read turnaround
  localparam logic [3:0] ALE_CYCLES     = 4'h4;
  localparam logic [3:0] ADDR_HOLD      = 4'h4;
  localparam logic [3:0] STROBE_CYCLES  = 4'ha;
  localparam logic [3:0] RELEASE_CYCLES = 4'h4;
  localparam logic [3:0] GAP_CYCLES     = 4'h4;
  localparam logic [3:0] CNT_ZERO       = 4'h0;
  localparam logic [3:0] CNT_ONE        = 4'h1;

  // ----------------------------------------------------------------
  // pin bundle as seen by the device
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       general_chip_select_n;
    logic       hdlc_regs_chip_select_n;
    logic       write_or_dir;
    logic       read_or_data_strobe;
    logic       addr_latch_en;
    logic [7:0] shared_bus;
    logic [7:0] addr;
  } hpbp_pins_t;

  localparam hpbp_pins_t PINS_IDLE = '{
    general_chip_select_n:   1'b1,
    hdlc_regs_chip_select_n: 1'b1,
    write_or_dir:            1'b1,
    read_or_data_strobe:     1'b1,
    addr_latch_en:           1'b0,
    shared_bus:              8'hff,
    addr:                    8'h00
  };

  // ----------------------------------------------------------------
  // state encodings
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    DEV_IDLE  = 3'b001,
    DEV_READ  = 3'b010,
    DEV_WRITE = 3'b100
  } hpbp_dev_state_t;

  typedef enum logic [5:0] {
    HOST_IDLE    = 6'b000001,
    HOST_ALE     = 6'b000010,
    HOST_LATCH   = 6'b000100,
    HOST_STROBE  = 6'b001000,
    HOST_RELEASE = 6'b010000,
    HOST_GAP     = 6'b100000
  } hpbp_host_state_t;

endpackage

/* File: tb/hpbp_properties.sv */
`timescale 1ns/1ps
// --------------------
// bus pin checker
// --------------------
module hpbp_properties (
  input wire logic       i_core_clk,
  input wire logic       i_sys_rst,
  input wire logic       general_chip_select_n,
  input wire logic       hdlc_regs_chip_select_n,
  input wire logic       write_or_dir,
  input wire logic       read_or_data_strobe,
  input wire logic       addr_latch_en,
  input wire logic [7:0] addr,
  input wire logic [7:0] host_bus_out,
  input wire logic       host_bus_oe_n,
  input wire logic [7:0] dev_bus_out,
  input wire logic       dev_bus_oe_n,
  input wire logic [7:0] shared_bus
);
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (i_sys_rst);

  // device only turns the bus around inside a read strobe
  chk_drive_in_read: assert property ($fell(dev_bus_oe_n) |->
    !read_or_data_strobe && write_or_dir) else $error("device drove bus outside a read");
  chk_no_bus_clash: assert property (!host_bus_oe_n |-> dev_bus_oe_n)
    else $error("host and device drive the bus together");
  // sync latency bounds how long the device may keep driving
  chk_drive_release: assert property ($rose(read_or_data_strobe) |->
    ##[0:5] dev_bus_oe_n) else $error("device kept driving after strobe end");
  chk_one_select: assert property (($fell(read_or_data_strobe) || $fell(write_or_dir)) |->
    general_chip_select_n ^ hdlc_regs_chip_select_n) else $error("not exactly one select low");
  chk_strobe_width: assert property ($fell(read_or_data_strobe) |->
    !read_or_data_strobe[*8]) else $error("strobe too short");
  chk_strobe_gap: assert property ($rose(read_or_data_strobe) |->
    read_or_data_strobe[*3]) else $error("strobe high time too short");
  chk_ale_addr_phase: assert property (addr_latch_en |->
    read_or_data_strobe && !host_bus_oe_n) else $error("bus not in address phase");
  chk_addr_at_fall: assert property ($fell(addr_latch_en) |->
    $stable(shared_bus) && !host_bus_oe_n) else $error("address unstable at latch");
  chk_read_released: assert property ($fell(read_or_data_strobe) && write_or_dir |->
    host_bus_oe_n) else $error("host still drives bus in read");
  // the host samples late in the strobe, so driven read data must hold still
  chk_rdata_steady: assert property (!dev_bus_oe_n && !$past(dev_bus_oe_n) |->
    $stable(dev_bus_out)) else $error("device read data changed while driven");
  chk_addr_steady: assert property (!read_or_data_strobe && !$past(read_or_data_strobe) |->
    $stable(addr)) else $error("address changed inside a strobe");
  chk_wdata_steady: assert property (!write_or_dir && !$past(write_or_dir) |->
    $stable(host_bus_out)) else $error("write data changed inside a write");

  cover property ($fell(dev_bus_oe_n));
  cover property ($fell(addr_latch_en));
  cover property ($fell(write_or_dir) && !host_bus_oe_n);
endmodule

/* File: tb/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
  logic       core_clk;
  logic       sys_rst = 1'b1;
  logic       mux_mode = 1'b0;
  logic       dir_style = 1'b0;
  logic       req = 1'b0;
  logic       wr = 1'b0;
  logic       hdlc = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic       done;
  logic       busy;
  logic [7:0] rd_data;
  logic       d_rd_stb;
  logic       d_wr_stb;
  logic       d_hdlc_sel;
  logic [7:0] d_addr;
  logic [7:0] d_wr_data;
  logic [7:0] d_rd_data;
  logic       mode_known;
  logic       d_mux;
  logic [7:0] cap_addr;
  logic [7:0] cap_data;
  logic       cap_hdlc;
  int         wr_cnt = 0;
  int         rd_cnt = 0;
  int         err_total = 0;
  int         n_tests = 0;

  // --------------------
  // structure
  // --------------------
  hpbp_if bif ();
  hpbp_host i_hpbp_host (.i_core_clk(core_clk), .i_sys_rst(sys_rst), .bus_if(bif.host),
    .i_mux_mode(mux_mode), .i_dir_style(dir_style), .i_req(req), .i_write(wr),
    .i_hdlc(hdlc), .i_addr(addr), .i_wdata(wdata), .o_busy(busy), .o_done(done),
    .o_rd_data(rd_data));
  hpbp_device i_hpbp_device (.i_core_clk(core_clk), .i_sys_rst(sys_rst),
    .bus_if(bif.device), .i_dir_style(dir_style), .o_rd_stb(d_rd_stb), .o_wr_stb(d_wr_stb),
    .o_hdlc_sel(d_hdlc_sel), .o_addr(d_addr), .o_wr_data(d_wr_data),
    .i_rd_data(d_rd_data), .o_mode_known(mode_known), .o_mux_mode(d_mux));
  hpbp_properties i_hpbp_properties (.i_core_clk(core_clk), .i_sys_rst(sys_rst),
    .general_chip_select_n(bif.general_chip_select_n),
    .hdlc_regs_chip_select_n(bif.hdlc_regs_chip_select_n),
    .write_or_dir(bif.write_or_dir), .read_or_data_strobe(bif.read_or_data_strobe),
    .addr_latch_en(bif.addr_latch_en), .addr(bif.addr), .host_bus_out(bif.host_bus_out),
    .host_bus_oe_n(bif.host_bus_oe_n), .dev_bus_out(bif.dev_bus_out),
    .dev_bus_oe_n(bif.dev_bus_oe_n), .shared_bus(bif.shared_bus));

  // register file stand-in: data tied to address so a wrong latch shows up
  assign d_rd_data = d_addr ^ (d_hdlc_sel ? 8'h5a : 8'ha5);

  // 125 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  // record what the device hands to its register side
  always @(posedge core_clk) begin
    if (d_wr_stb === 1'b1 || d_rd_stb === 1'b1) begin
      wr_cnt += (d_wr_stb === 1'b1);
      rd_cnt += (d_rd_stb === 1'b1);
      cap_addr = d_addr;
      cap_hdlc = d_hdlc_sel;
      cap_data = d_wr_data;
    end
  end

  // --------------------
  // compare and closing
  // --------------------
  task automatic chk_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  task automatic chk_bit(input string what, input logic exp, input logic got);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected %s: expected %b, seen %b", what, exp, got);
    end
  endtask

  task automatic end_of_test;
    if (err_total == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // --------------------
  // bus tasks
  // --------------------
  task automatic do_reset(input logic m, input logic d);
    sys_rst = 1'b1;
    mux_mode = m;
    dir_style = d;
    repeat (6) @(posedge core_clk);
    #1 sys_rst = 1'b0;
  endtask

  // one host request; returns in the done cycle so calls run back to back
  task automatic do_acc(input logic w, input logic h, input logic [7:0] a, input logic [7:0] d,
                        input logic full);
    int w0;
    int r0;
    int cyc;
    int exp_cyc;
    w0 = wr_cnt;
    r0 = rd_cnt;
    // phase lengths load n and last n+1 cycles; the latch phases add two more
    exp_cyc = hpbp_pkg::STROBE_CYCLES + hpbp_pkg::RELEASE_CYCLES + hpbp_pkg::GAP_CYCLES + 3;
    if (mux_mode) begin
      exp_cyc += hpbp_pkg::ALE_CYCLES + hpbp_pkg::ADDR_HOLD + 2;
    end
    req = 1'b1;
    wr = w;
    hdlc = h;
    addr = a;
    wdata = d;
    @(posedge core_clk);
    #1 chk_bit("busy", 1'b1, busy);
    // request stays up one more edge; a busy host must not take it again
    @(posedge core_clk);
    #1 req = 1'b0;
    cyc = 1;
    while (done !== 1'b1 && cyc < 60) begin
      @(posedge core_clk);
      #1 cyc++;
    end
    chk_bit("done", 1'b1, done);
    chk_byte("cycles", 8'(exp_cyc), 8'(cyc));
    chk_bit("busy", 1'b0, busy);
    chk_byte("write count", 8'(w0 + w), 8'(wr_cnt));
    chk_byte("read count", 8'(r0 + !w), 8'(rd_cnt));
    chk_bit("controller select", h, cap_hdlc);
    chk_byte("released bus", hpbp_pkg::BUS_IDLE, bif.shared_bus);
    if (w) begin
      chk_byte("write data", d, cap_data);
    end
    if (full) begin
      chk_byte("device address", a, cap_addr);
    end
    if (full && !w) begin
      chk_byte("read data", a ^ (h ? 8'h5a : 8'ha5), rd_data);
    end
  endtask

  // --------------------
  // scenarios
  // --------------------
  task automatic sc_mode(input logic m, input logic d);
    do_reset(m, d);
    chk_bit("mode known", 1'b0, mode_known);
    for (int i = 0; i < 4; i++) begin
      do_acc(!i[0], i[1], 8'h0f << i, 8'hf0 >> i, 1'b1);
    end
    chk_bit("mode known", 1'b1, mode_known);
    chk_bit("mux mode", m, d_mux);
  endtask

  // host switches to latch style after the mode is fixed; address is then meaningless
  task automatic sc_mode_hold;
    do_reset(1'b0, 1'b0);
    do_acc(1'b0, 1'b0, 8'h81, 8'h00, 1'b1);
    mux_mode = 1'b1;
    do_acc(1'b1, 1'b1, 8'h42, 8'h3c, 1'b0);
    chk_bit("mux mode held", 1'b0, d_mux);
    mux_mode = 1'b0;
  endtask

  // main sequence
  initial begin
    sc_mode(1'b0, 1'b0);
    sc_mode(1'b1, 1'b1);
    sc_mode(1'b1, 1'b0);
    sc_mode(1'b0, 1'b1);
    sc_mode_hold;
    end_of_test;
  end

  // watchdog: run needs under a thousand cycles
  initial begin
    repeat (5000) @(posedge core_clk);
    err_total++;
    end_of_test;
  end
endmodule
